//--- rtl/nfcopc_ctrl.sv
// The APB register port was left to the implementer.
`include "nfcopc_consts.svh"

// Summary of operation
// - Bit 7 turns oscillator and regulators on (Ready) or off.
// - Bit 6 enables the receiver.
// - Bit 5 set leaves one channel active, picked by channel_choice.
// - Bit 4 picks manual channel choice instead of automatic, both channels on.
// - Bit 3 enables transmit; set by field-on, cleared after active transmit.
// - Bit 2 enters wake-up mode, driven by wake-up timer settings.
// - Field detector code: off, collision threshold, peer threshold, automatic.
// - Operation control resets to zero only at power-up.
// - Mode bit 7 picks initiator or target; mode code defaults to 0001.
// - Mode bit 2 picks OOK or AM modulation.
// - Mode register is written only while the crystal is stable.
// - Initiator codes: A, B, type 1, stream modes; others reserved.
// - Unsupported mode code disables transmit and receive.
// - Target codes 0001 and 0100 passive; other non-detect codes not allowed.
// - Target top bit runs rate detection; bit 2 and bit 0 pick protocols.
// - Rate bits 5:4 give transmit rate; bits 7:6 reserved.
// - Rate bits 1:0 give receive rate; bits 3:2 reserved.
// - Rate codes give fc/128 to fc/16; unsupported codes disable transmit, receive.
module nfcopc_ctrl
   import nfcopc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic power_on_reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic crystal_stable_flag_i,
   input wire logic channel_choice_i,
   input wire logic field_on_cmd_i,
   input wire logic active_tx_done_i,
   output logic osc_reg_enable_o,
   output logic rx_active_o,
   output logic tx_active_o,
   output logic am_channel_on_o,
   output logic pm_channel_on_o,
   output logic auto_channel_o,
   output logic wakeup_active_o,
   output logic [1:0] field_detector_control_o,
   output logic low_power_mode_o,
   output logic target_role_o,
   output logic [3:0] protocol_o,
   output logic detect_type_f_o,
   output logic detect_type_a_o,
   output logic am_modulation_select_o,
   output logic [1:0] tx_rate_o,
   output logic [1:0] rx_rate_o,
   output logic [1:0] power_state_o
);

   // Byte addresses of the register words reach 0x44
   if (ADDR_W < 8) begin : g_addr_w_check
      $error("ADDR_W must be at least 8");
   end

   // ********************
   // Pin synchronisers
   // ********************
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic xtal_ok;
   logic ch_choice;
   logic field_on_lvl;
   logic tx_done_lvl;
   logic field_on_prev_q;
   logic tx_done_prev_q;
   logic field_on_evt;
   logic tx_done_evt;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {active_tx_done_i, field_on_cmd_i,
                     channel_choice_i, crystal_stable_flag_i};
         sync2_q <= sync1_q;
      end
   end

   assign xtal_ok = sync2_q[0];
   assign ch_choice = sync2_q[1];
   assign field_on_lvl = sync2_q[2];
   assign tx_done_lvl = sync2_q[3];

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         field_on_prev_q <= 1'b0;
         tx_done_prev_q <= 1'b0;
      end else begin
         field_on_prev_q <= field_on_lvl;
         tx_done_prev_q <= tx_done_lvl;
      end
   end

   assign field_on_evt = field_on_lvl & ~field_on_prev_q;
   assign tx_done_evt = tx_done_lvl & ~tx_done_prev_q;

   // ********************
   // APB decode
   // ********************
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en, input logic [7:0] wmask);
      merge = en ? (nw & wmask) : old;
   endfunction

   logic access;
   logic commit;
   logic wr;
   logic hit_oc;
   logic hit_md;
   logic hit_br;
   logic hit_ev;
   logic hit_st;
   logic mapped;
   logic lane0;

   assign access = psel_i & penable_i & ~pready_o;
   // Writes land on the completing edge, where the master samples pready high
   assign commit = psel_i & penable_i & pready_o;
   assign wr = commit & pwrite_i;
   assign hit_oc = hit(paddr_i, `NFCOPC_IDX_OPCTL);
   assign hit_md = hit(paddr_i, `NFCOPC_IDX_MODE);
   assign hit_br = hit(paddr_i, `NFCOPC_IDX_RATE);
   assign hit_ev = hit(paddr_i, `NFCOPC_IDX_EVENT);
   assign hit_st = hit(paddr_i, `NFCOPC_IDX_STATUS);
   assign mapped = hit_oc | hit_md | hit_br | hit_ev | hit_st;
   assign lane0 = pstrb_i[0];

   // ********************
   // Registers
   // ********************
   logic [7:0] opctl_q;
   logic [7:0] opctl_d;
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic [7:0] rate_q;
   logic [7:0] rate_d;
   logic mode_refused_q;
   logic mode_refused_d;
   logic wr_oc;
   logic wr_md;
   logic wr_ev;
   logic wr_br;
   logic active_mode;
   logic [7:0] opctl_sw;

   assign wr_oc = wr & hit_oc & lane0;
   assign wr_md = wr & hit_md & lane0 & xtal_ok;
   assign wr_ev = wr & hit_ev & lane0;
   assign wr_br = wr & hit_br & lane0;
   assign opctl_sw = merge(opctl_q, pwdata_i[7:0], wr_oc, 8'hFF);

   // Hardware set of tx enable wins over a software clear in the same cycle
   always_comb begin
      opctl_d = opctl_sw;
      if (tx_done_evt && active_mode) begin
         opctl_d[`NFCOPC_OC_TX_EN] = 1'b0;
      end
      if (field_on_evt) begin
         opctl_d[`NFCOPC_OC_TX_EN] = 1'b1;
      end
   end

   assign mode_d = merge(mode_q, pwdata_i[7:0], wr_md, `NFCOPC_MD_WMASK);
   assign rate_d = merge(rate_q, pwdata_i[7:0], wr_br, `NFCOPC_BR_WMASK);

   // Refused mode write is sticky; new refusal wins over the clear
   assign mode_refused_d = (wr & hit_md & lane0 & ~xtal_ok) |
                           (mode_refused_q & ~(wr_ev & pwdata_i[0]));

   // Operation control keeps its value through a plain reset; only power-up clears it
   always_ff @(posedge clk_sys_i or negedge power_on_reset_n_i) begin
      if (!power_on_reset_n_i) begin
         opctl_q <= `NFCOPC_RST_OPCTL;
      end else begin
         opctl_q <= opctl_d;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= `NFCOPC_RST_MODE;
         rate_q <= `NFCOPC_RST_RATE;
         mode_refused_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         rate_q <= rate_d;
         mode_refused_q <= mode_refused_d;
      end
   end

   // ********************
   // Mode decode
   // ********************
   logic [3:0] om;
   logic target;
   logic mode_ok;
   logic rate_ok;
   logic op_ok;
   nfcopc_prot_t prot;

   assign om = mode_q[`NFCOPC_MD_OM_HI:`NFCOPC_MD_OM_LO];
   assign target = mode_q[`NFCOPC_MD_TARGET];
   // Stream modes are initiator codes with the top two bits set; treated as active
   assign active_mode = ~target & (om[3:2] == 2'b11);

   always_comb begin
      prot = NFCOPC_PROT_NONE;
      if (!target) begin
         case (om)
            `NFCOPC_OM_14443A: prot = NFCOPC_PROT_14443A;
            `NFCOPC_OM_14443B: prot = NFCOPC_PROT_14443B;
            `NFCOPC_OM_TYPE1: prot = NFCOPC_PROT_TYPE1;
            `NFCOPC_OM_SUBC: prot = NFCOPC_PROT_SUBC;
            `NFCOPC_OM_BPSK: prot = NFCOPC_PROT_BPSK;
            default: prot = NFCOPC_PROT_NONE;
         endcase
      end else if (om[3]) begin
         prot = NFCOPC_PROT_DETECT;
      end else begin
         case (om)
            `NFCOPC_OM_TGT_A: prot = NFCOPC_PROT_TGT_A;
            `NFCOPC_OM_TGT_F: prot = NFCOPC_PROT_TGT_F;
            default: prot = NFCOPC_PROT_NONE;
         endcase
      end
   end

   // Rate fields are two bits wide, so every stored code is supported
   assign rate_ok = 1'b1;
   assign mode_ok = (prot != NFCOPC_PROT_NONE);
   assign op_ok = mode_ok & rate_ok;

   // ********************
   // Power state
   // ********************
   logic low_power;
   nfcopc_pstate_t pstate;

   assign low_power = (opctl_q[1:0] != 2'b00) && (opctl_q[7:2] == 6'h00);
   always_comb begin
      case ({opctl_q[`NFCOPC_OC_OSC_EN], opctl_q[`NFCOPC_OC_WAKEUP]})
         2'b10, 2'b11: pstate = NFCOPC_PS_READY;
         2'b01: pstate = NFCOPC_PS_WAKEUP;
         default: pstate = low_power ? NFCOPC_PS_LOWPWR : NFCOPC_PS_OFF;
      endcase
   end

   // ********************
   // Outputs
   // ********************
   logic single;
   logic [31:0] rdata;

   assign single = opctl_q[`NFCOPC_OC_SINGLE_CH];
   assign rdata = hit_oc ? {24'h00_0000, opctl_q} :
                  hit_md ? {24'h00_0000, mode_q} :
                  hit_br ? {24'h00_0000, rate_q} :
                  hit_ev ? {31'h0000_0000, mode_refused_q} :
                  hit_st ? {24'h00_0000, xtal_ok, op_ok, pstate, prot} : 32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= access;
         pslverr_o <= access & ~mapped;
         prdata_o <= (access & ~pwrite_i) ? rdata : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_reg_enable_o <= 1'b0;
         rx_active_o <= 1'b0;
         tx_active_o <= 1'b0;
         am_channel_on_o <= 1'b0;
         pm_channel_on_o <= 1'b0;
         auto_channel_o <= 1'b0;
         wakeup_active_o <= 1'b0;
         field_detector_control_o <= 2'b00;
         low_power_mode_o <= 1'b0;
         target_role_o <= 1'b0;
         protocol_o <= 4'h0;
         detect_type_f_o <= 1'b0;
         detect_type_a_o <= 1'b0;
         am_modulation_select_o <= 1'b0;
         tx_rate_o <= 2'b00;
         rx_rate_o <= 2'b00;
         power_state_o <= 2'b00;
      end else begin
         osc_reg_enable_o <= opctl_q[`NFCOPC_OC_OSC_EN];
         rx_active_o <= opctl_q[`NFCOPC_OC_RX_EN] & op_ok;
         tx_active_o <= opctl_q[`NFCOPC_OC_TX_EN] & op_ok;
         am_channel_on_o <= ~single | ~ch_choice;
         pm_channel_on_o <= ~single | ch_choice;
         auto_channel_o <= ~single & ~opctl_q[`NFCOPC_OC_MAN_CH];
         wakeup_active_o <= opctl_q[`NFCOPC_OC_WAKEUP];
         field_detector_control_o <= opctl_q[1:0];
         low_power_mode_o <= low_power;
         target_role_o <= target;
         protocol_o <= prot;
         detect_type_f_o <= (prot == NFCOPC_PROT_DETECT) & om[2];
         detect_type_a_o <= (prot == NFCOPC_PROT_DETECT) & om[0];
         am_modulation_select_o <= mode_q[`NFCOPC_MD_AM];
         tx_rate_o <= rate_q[`NFCOPC_BR_TX_HI:`NFCOPC_BR_TX_LO];
         rx_rate_o <= rate_q[`NFCOPC_BR_RX_HI:`NFCOPC_BR_RX_LO];
         power_state_o <= pstate;
      end
   end

endmodule // nfcopc_ctrl

//--- common/nfcopc_consts.svh
`ifndef NFCOPC_CONSTS_SVH
`define NFCOPC_CONSTS_SVH

// ********************
// Register offsets (byte addresses = 4 x index)
// ********************
`define NFCOPC_IDX_OPCTL 8'h02
`define NFCOPC_IDX_MODE 8'h03
`define NFCOPC_IDX_RATE 8'h04
`define NFCOPC_IDX_EVENT 8'h10
`define NFCOPC_IDX_STATUS 8'h11

// ********************
// Operation control fields
// ********************
`define NFCOPC_OC_OSC_EN 7
`define NFCOPC_OC_RX_EN 6
`define NFCOPC_OC_SINGLE_CH 5
`define NFCOPC_OC_MAN_CH 4
`define NFCOPC_OC_TX_EN 3
`define NFCOPC_OC_WAKEUP 2
`define NFCOPC_OC_FD_HI 1
`define NFCOPC_OC_FD_LO 0

// ********************
// Mode definition fields
// ********************
`define NFCOPC_MD_TARGET 7
`define NFCOPC_MD_OM_HI 6
`define NFCOPC_MD_OM_LO 3
`define NFCOPC_MD_AM 2
`define NFCOPC_MD_WMASK 8'hFC

// ********************
// Bit rate fields
// ********************
`define NFCOPC_BR_TX_HI 5
`define NFCOPC_BR_TX_LO 4
`define NFCOPC_BR_RX_HI 1
`define NFCOPC_BR_RX_LO 0
`define NFCOPC_BR_WMASK 8'h33

// ********************
// Reset values
// ********************
`define NFCOPC_RST_OPCTL 8'h00
`define NFCOPC_RST_MODE 8'h08
`define NFCOPC_RST_RATE 8'h00

// ********************
// Operation mode codes
// ********************
`define NFCOPC_OM_14443A 4'h1
`define NFCOPC_OM_14443B 4'h2
`define NFCOPC_OM_TYPE1 4'h4
`define NFCOPC_OM_SUBC 4'hC
`define NFCOPC_OM_BPSK 4'hD
`define NFCOPC_OM_TGT_A 4'h1
`define NFCOPC_OM_TGT_F 4'h4

`endif

//--- common/nfcopc_pkg.sv
package nfcopc_pkg;
   typedef enum logic [1:0] {
      NFCOPC_FD_OFF = 2'h0,
      NFCOPC_FD_CA = 2'h1,
      NFCOPC_FD_PEER = 2'h2,
      NFCOPC_FD_AUTO = 2'h3
   } nfcopc_fd_t;

   typedef enum logic [3:0] {
      NFCOPC_PROT_NONE = 4'h0,
      NFCOPC_PROT_14443A = 4'h1,
      NFCOPC_PROT_14443B = 4'h2,
      NFCOPC_PROT_TYPE1 = 4'h3,
      NFCOPC_PROT_SUBC = 4'h4,
      NFCOPC_PROT_BPSK = 4'h5,
      NFCOPC_PROT_TGT_A = 4'h6,
      NFCOPC_PROT_TGT_F = 4'h7,
      NFCOPC_PROT_DETECT = 4'h8
   } nfcopc_prot_t;

   // Power state of the device, Gray coded along off -> low power -> ready -> wake-up
   typedef enum logic [1:0] {
      NFCOPC_PS_OFF = 2'b00,
      NFCOPC_PS_LOWPWR = 2'b01,
      NFCOPC_PS_READY = 2'b11,
      NFCOPC_PS_WAKEUP = 2'b10
   } nfcopc_pstate_t;
endpackage

//--- test/nfcopc_ctrl_chk.sv
module nfcopc_ctrl_chk
   import nfcopc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic power_on_reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic osc_reg_enable_o,
   input wire logic rx_active_o,
   input wire logic tx_active_o,
   input wire logic am_channel_on_o,
   input wire logic pm_channel_on_o,
   input wire logic auto_channel_o,
   input wire logic wakeup_active_o,
   input wire logic [1:0] field_detector_control_o,
   input wire logic low_power_mode_o,
   input wire logic target_role_o,
   input wire logic [3:0] protocol_o,
   input wire logic detect_type_f_o,
   input wire logic detect_type_a_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i || !power_on_reset_n_i);

   a_pready_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
   a_answer_slot: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("no answer");
   a_err_pair: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
   a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   a_lowpwr_cond: assert property (low_power_mode_o |-> field_detector_control_o != 2'h0
      && !osc_reg_enable_o && !wakeup_active_o && !rx_active_o && !tx_active_o)
      else $error("low power with other bits");
   a_both_chan: assert property (auto_channel_o |-> am_channel_on_o && pm_channel_on_o)
      else $error("auto without both channels");
   a_unsup_off: assert property (protocol_o == NFCOPC_PROT_NONE |->
      !tx_active_o && !rx_active_o) else $error("unsupported mode active");
   a_detect_role: assert property ((detect_type_a_o || detect_type_f_o) |-> target_role_o
      && protocol_o == NFCOPC_PROT_DETECT) else $error("detect outside target");
   a_target_codes: assert property (target_role_o |-> protocol_o inside {NFCOPC_PROT_NONE,
      NFCOPC_PROT_TGT_A, NFCOPC_PROT_TGT_F, NFCOPC_PROT_DETECT}) else $error("bad target code");
endmodule // nfcopc_ctrl_chk

bind nfcopc_ctrl nfcopc_ctrl_chk u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
   .power_on_reset_n_i(power_on_reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .osc_reg_enable_o(osc_reg_enable_o), .rx_active_o(rx_active_o), .tx_active_o(tx_active_o),
   .am_channel_on_o(am_channel_on_o), .pm_channel_on_o(pm_channel_on_o),
   .auto_channel_o(auto_channel_o), .wakeup_active_o(wakeup_active_o),
   .field_detector_control_o(field_detector_control_o), .low_power_mode_o(low_power_mode_o),
   .target_role_o(target_role_o), .protocol_o(protocol_o), .detect_type_f_o(detect_type_f_o),
   .detect_type_a_o(detect_type_a_o));

//--- test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_i = 0, reset_n_i = 0, power_on_reset_n_i = 0, psel_i = 0, penable_i = 0;
   logic pwrite_i = 0, crystal_stable_flag_i = 1, channel_choice_i = 0;
   logic field_on_cmd_i = 0, active_tx_done_i = 0;
   logic [7:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, v;
   logic [3:0] pstrb_i = 4'hF, protocol_o;
   logic pready_o, pslverr_o, osc_reg_enable_o, rx_active_o, tx_active_o, am_channel_on_o;
   logic pm_channel_on_o, auto_channel_o, wakeup_active_o, low_power_mode_o, target_role_o;
   logic detect_type_f_o, detect_type_a_o, am_modulation_select_o;
   logic [1:0] field_detector_control_o, tx_rate_o, rx_rate_o, power_state_o;
   logic [7:0] m_op = 0, m_md = 8'h08, m_rt = 0;
   logic [31:0] seed = 32'h0000_0010;
   int failures = 0, comparisons = 0;

   nfcopc_ctrl DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .power_on_reset_n_i(power_on_reset_n_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .crystal_stable_flag_i(crystal_stable_flag_i),
      .channel_choice_i(channel_choice_i), .field_on_cmd_i(field_on_cmd_i),
      .active_tx_done_i(active_tx_done_i), .osc_reg_enable_o(osc_reg_enable_o),
      .rx_active_o(rx_active_o), .tx_active_o(tx_active_o), .am_channel_on_o(am_channel_on_o),
      .pm_channel_on_o(pm_channel_on_o), .auto_channel_o(auto_channel_o),
      .wakeup_active_o(wakeup_active_o), .field_detector_control_o(field_detector_control_o),
      .low_power_mode_o(low_power_mode_o), .target_role_o(target_role_o),
      .protocol_o(protocol_o), .detect_type_f_o(detect_type_f_o),
      .detect_type_a_o(detect_type_a_o), .am_modulation_select_o(am_modulation_select_o),
      .tx_rate_o(tx_rate_o), .rx_rate_o(rx_rate_o), .power_state_o(power_state_o));

   always #12.5 clk_sys_i = ~clk_sys_i;

   // ********************
   // Bus and compare helpers
   // ********************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [3:0] exp_prot(logic [7:0] m);
      logic [3:0] o;
      o = m[6:3];
      if (m[7]) return o[3] ? 4'h8 : o == 4'h1 ? 4'h6 : o == 4'h4 ? 4'h7 : 4'h0;
      return o == 4'h1 ? 4'h1 : o == 4'h2 ? 4'h2 : o == 4'h4 ? 4'h3 :
         o == 4'hC ? 4'h4 : o == 4'hD ? 4'h5 : 4'h0;
   endfunction

   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge clk_sys_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1;
      n = 0;
      // The answer is taken as it stands at the rising edge with pready high
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20 && pready_o !== 1'b1) begin
         failures++;
         complete_run();
      end else begin
         r = prdata_o;
         e = pslverr_o;
         psel_i <= 0;
         penable_i <= 0;
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d, logic ek);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
      chk("wr_err", ek, e);
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] x, logic ek);
      logic [31:0] r;
      logic e;
      apb(0, a, 0, r, e);
      chk("rdata", x, r);
      chk("rd_err", ek, e);
   endtask

   // Outputs lag the registers, so let two cycles pass first
   task automatic pins();
      logic [3:0] p;
      logic [1:0] s;
      p = exp_prot(m_md);
      s = m_op[7] ? 2'h3 : m_op[2] ? 2'h2 : {1'b0, m_op[1:0] != 0 && m_op[7:2] == 0};
      repeat (2) @(negedge clk_sys_i);
      chk("osc", m_op[7], osc_reg_enable_o);
      chk("rx", m_op[6] && p != 0, rx_active_o);
      chk("tx", m_op[3] && p != 0, tx_active_o);
      chk("am_ch", !m_op[5] || !channel_choice_i, am_channel_on_o);
      chk("pm_ch", !m_op[5] || channel_choice_i, pm_channel_on_o);
      chk("auto", !m_op[5] && !m_op[4], auto_channel_o);
      chk("wake", m_op[2], wakeup_active_o);
      chk("fd", m_op[1:0], field_detector_control_o);
      chk("lowpwr", m_op[1:0] != 0 && m_op[7:2] == 0, low_power_mode_o);
      chk("targ", m_md[7], target_role_o);
      chk("prot", p, protocol_o);
      chk("det_a", m_md[7] && m_md[6] && m_md[3], detect_type_a_o);
      chk("det_f", m_md[7] && m_md[6] && m_md[5], detect_type_f_o);
      chk("am", m_md[2], am_modulation_select_o);
      chk("txr", m_rt[5:4], tx_rate_o);
      chk("rxr", m_rt[1:0], rx_rate_o);
      chk("pstate", s, power_state_o);
      rd(8'h44, {1'b1, p != 0, s, p}, 0);
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      repeat (2) @(posedge clk_sys_i);
      reset_n_i <= 1;
      power_on_reset_n_i <= 1;
      rd(8'h08, 0, 0);
      rd(8'h0C, 8'h08, 0);
      rd(8'h10, 0, 0);
      for (int i = 0; i < 12; i++) begin
         v = rnd();
         channel_choice_i <= v[24];
         m_op = i < 4 ? i[7:0] : v[7:0];
         m_md = v[15:8] & 8'hFC;
         m_rt = v[23:16] & 8'h33;
         wr(8'h08, m_op, 0);
         wr(8'h0C, m_md, 0);
         wr(8'h10, m_rt, 0);
         rd(8'h08, m_op, 0);
         rd(8'h0C, m_md, 0);
         pins();
      end
      wr(8'h10, 8'hFF, 0);
      m_rt = 8'h33;
      rd(8'h10, m_rt, 0);
      pstrb_i <= 4'hE;
      wr(8'h10, 8'h11, 0);
      pstrb_i <= 4'hF;
      rd(8'h10, m_rt, 0);
      m_op = 8'hC8;
      wr(8'h08, m_op, 0);
      for (int c = 0; c < 32; c++) begin
         v = rnd();
         m_md = {c[4:0], v[0], 2'b00};
         wr(8'h0C, m_md, 0);
         pins();
      end
      crystal_stable_flag_i <= 0;
      repeat (4) @(posedge clk_sys_i);
      wr(8'h0C, 8'h88, 0);
      rd(8'h0C, m_md, 0);
      rd(8'h40, 1, 0);
      wr(8'h40, 1, 0);
      rd(8'h40, 0, 0);
      crystal_stable_flag_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      m_md = 8'h60;
      wr(8'h0C, m_md, 0);
      m_op = 8'h81;
      wr(8'h08, m_op, 0);
      field_on_cmd_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      field_on_cmd_i <= 0;
      m_op = 8'h89;
      rd(8'h08, m_op, 0);
      active_tx_done_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      active_tx_done_i <= 0;
      m_op = 8'h81;
      rd(8'h08, m_op, 0);
      reset_n_i <= 0;
      @(posedge clk_sys_i);
      reset_n_i <= 1;
      rd(8'h08, m_op, 0);
      rd(8'h0C, 8'h08, 0);
      power_on_reset_n_i <= 0;
      @(posedge clk_sys_i);
      power_on_reset_n_i <= 1;
      rd(8'h08, 0, 0);
      wr(8'h20, 8'h5A, 1);
      rd(8'h20, 0, 1);
      complete_run();
   end
endmodule // tb
